// [rtl/phd_arbiter.sv]
`timescale 1ns/10ps
module phd_arbiter
   import phd_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [NCH-1:0] req,
   input wire logic [NCH-1:0][2:0] prio,
   input wire logic [NCH-1:0] rr_off,
   input wire logic fair_en,
   input wire logic take,
   output logic gnt_valid,
   output logic [CHW-1:0] gnt_ch
);
   logic [5:0] slot_q;
   logic [CHW-1:0] last_q;
   logic [7:0] has;
   logic [2:0] best, fav, lvl;
   logic found;
   int idx;
   always_comb begin
      idx = 0;
      has = '0;
      for (int i = 0; i < NCH; i++) has[prio[i]] = has[prio[i]] | req[i];
      best = 3'h7;
      for (int l = 7; l >= 0; l--) if (has[l]) best = 3'(l); // [RULE9]
      // slot schedule: lowest set bit b of the slot count favours level 2+b [RULE23]
      fav = 3'h7;
      for (int b = 5; b >= 0; b--) if (slot_q[b]) fav = 3'(LVL_FAIR_MIN + b);
      // levels 0/1 bypass the schedule; fairness off is strict priority [RULE19] [RULE22]
      lvl = (has[0] || has[1] || !fair_en || !has[fav]) ? best : fav; // [RULE18]
      gnt_valid = |req;
      gnt_ch = '0;
      found = 1'b0;
      for (int i = 0; i < NCH; i++) begin
         if (!found && req[i] && rr_off[i] && prio[i] == lvl) begin // [RULE21]
            found = 1'b1;
            gnt_ch = CHW'(i);
         end
      end
      for (int k = 1; k <= NCH; k++) begin
         idx = (int'(last_q) + k) % NCH;
         if (!found && req[idx] && prio[idx] == lvl) begin // [RULE20]
            found = 1'b1;
            gnt_ch = CHW'(idx);
         end
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         slot_q <= 6'h0;
         last_q <= '0;
      end else if (take) begin
         slot_q <= slot_q + 6'h1;
         last_q <= gnt_ch;
      end
   end
endmodule : phd_arbiter

// [rtl/phd_hub.sv]
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/10ps
// Operation
// [RULE1] cpu and dma engine are the two masters onto the spokes
// [RULE2] eight spokes, each with its own independent request path
// [RULE3] cpu and dma on different spokes proceed in the same cycles
// [RULE4] next source read overlaps current destination write on other spokes
// [RULE5] each access carries 1 to 4 bytes on 32-bit address and data
// [RULE6] address bits select the spoke: sram, io, config, analog, comm, filter, logic
// [RULE7] 24 channels sharing a pool of 128 descriptors
// [RULE8] descriptors are readable and writable registers on the bus
// [RULE9] each channel has a 3-bit priority, zero being highest
// [RULE10] channels start from synchronised trigger pins, software, or another channel
// [RULE11] two interrupt pulses per channel: descriptor done and chain done
// [RULE12] stall masks a channel until cleared; cancel drops it after current burst (the code stops issuing reads at once and ends when accesses in flight finish)
// [RULE13] length 1 to 65536 bytes, zero field meaning 65536, or endless
// [RULE14] a finished descriptor continues at its linked next descriptor
// [RULE15] a descriptor may link to itself and restart from its stored setup
// [RULE16] cpu wins a contended spoke, but dma always gets the next turn
// [RULE17] higher priority takes over only at a burst boundary
// [RULE18] with fairness on, levels 2 to 7 get halving shares of slots
// [RULE19] levels 0 and 1 are served ahead of the fairness schedule
// [RULE20] equal-priority channels rotate round robin
// [RULE21] a channel with rotation off always wins its own level
// [RULE22] fairness off gives pure priority order
// [RULE23] fairness is a repeating binary-weighted slot schedule
module phd_hub
   import phd_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cpu_req,
   input wire logic [31:0] cpu_addr,
   input wire logic cpu_write,
   input wire logic [31:0] cpu_wdata,
   input wire logic [1:0] cpu_size,
   output logic cpu_done,
   output logic [31:0] cpu_rdata,
   output logic [NSP-1:0] sp_valid,
   output logic [NSP-1:0] sp_write,
   output logic [NSP-1:0][31:0] sp_addr,
   output logic [NSP-1:0][31:0] sp_wdata,
   output logic [NSP-1:0][1:0] sp_size,
   input wire logic [NSP-1:0] sp_ready,
   input wire logic [NSP-1:0][31:0] sp_rdata,
   input wire logic [NCH-1:0] trig_in,
   output logic [NCH-1:0] ch_irq_td,
   output logic [NCH-1:0] ch_irq_chain
);
   ////////////////////////////////////////////////////////////////////////////
   // register storage
   logic fair_en_q;
   logic [NCH-1:0] stall_q;
   logic [CHCFG_W-1:0] chcfg_q [NCH];
   logic [31:0] td_src_q [NTD];
   logic [31:0] td_dst_q [NTD];
   logic [31:0] td_cfg_q [NTD];
   // channel state
   logic [NCH-1:0] pend_q, run_q, mid_q, cancel_q;
   logic [TDW-1:0] ch_td_q [NCH];
   logic [31:0] ch_src_q [NCH];
   logic [31:0] ch_dst_q [NCH];
   logic [16:0] ch_rem_q [NCH];
   logic [NCH-1:0] trig_s1_q, trig_s2_q, trig_s3_q;
   // engine
   phd_state_e st_q;
   logic [CHW-1:0] act_q;
   logic [TDW-1:0] td_q;
   logic [31:0] cfg_q, src_q, dst_q, hold_q, wr_data_q;
   logic [16:0] rd_rem_q, wr_rem_q;
   logic [2:0] rd_n_q, wr_n_q, hold_b_q;
   logic [1:0] rd_sz_q, wr_sz_q;
   logic hold_v_q, rd_req_q, wr_req_q;
   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire [11:0] a = paddr[11:0];
   wire is_ch = a >= A_CH && a < A_CH_END;
   wire is_td = a >= A_TD;
   wire [CHW-1:0] a_ch = CHW'((a - A_CH) >> 2);
   wire [TDW-1:0] a_td = a[10:4];
   wire [1:0] a_w = a[3:2];
   wire is_reg = a == A_CTRL || a == A_STAT || a == A_TRIG || a == A_STALL ||
                 a == A_CANCEL || a == A_PEND;
   wire hit = is_reg || is_ch || is_td;
   wire acc = psel && penable;
   wire wr_ok = acc && pready && pwrite && hit;
   wire [NCH-1:0] apb_trig = (wr_ok && a == A_TRIG) ? pwdata[NCH-1:0] : '0;
   wire [NCH-1:0] apb_cancel = (wr_ok && a == A_CANCEL) ? pwdata[NCH-1:0] : '0;
   wire busy = st_q != ST_IDLE;
   logic [31:0] rdv;
   always_comb begin
      rdv = 32'h0;
      if (a == A_CTRL) rdv = {31'h0, fair_en_q};
      else if (a == A_STAT) rdv = {19'h0, td_q, act_q, busy};
      else if (a == A_STALL) rdv = {8'h0, stall_q};
      else if (a == A_PEND) rdv = {8'h0, pend_q};
      else if (is_ch) rdv = {14'h0, chcfg_q[a_ch]};
      else if (is_td && a_w == 2'h0) rdv = td_src_q[a_td]; // [RULE8]
      else if (is_td && a_w == 2'h1) rdv = td_dst_q[a_td];
      else if (is_td && a_w == 2'h2) rdv = td_cfg_q[a_td];
   end
   // one wait state so read data comes from a flop
   always_ff @(posedge clk) begin
      if (reset) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= acc && !pready;
         pslverr <= acc && !pready && !hit;
         prdata <= (acc && !pready && !pwrite) ? rdv : 32'h0;
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         fair_en_q <= 1'b0;
         stall_q <= '0;
         for (int i = 0; i < NCH; i++) chcfg_q[i] <= '0;
      end else if (wr_ok) begin
         if (a == A_CTRL) fair_en_q <= pwdata[0];
         if (a == A_STALL) stall_q <= pwdata[NCH-1:0]; // [RULE12]
         if (is_ch) chcfg_q[a_ch] <= pwdata[CHCFG_W-1:0];
      end
   end
   // descriptor pool is plain storage, left unreset
   always_ff @(posedge clk) begin
      if (wr_ok && is_td) begin // [RULE7]
         if (a_w == 2'h0) td_src_q[a_td] <= pwdata;
         if (a_w == 2'h1) td_dst_q[a_td] <= pwdata;
         if (a_w == 2'h2) td_cfg_q[a_td] <= pwdata;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // trigger pins: two flops, then edge detect on the second
   always_ff @(posedge clk) begin
      if (reset) begin
         trig_s1_q <= '0;
         trig_s2_q <= '0;
         trig_s3_q <= '0;
      end else begin
         trig_s1_q <= trig_in;
         trig_s2_q <= trig_s1_q;
         trig_s3_q <= trig_s2_q;
      end
   end
   wire [NCH-1:0] trig_rise = trig_s2_q & ~trig_s3_q;
   ////////////////////////////////////////////////////////////////////////////
   // end-of-burst events
   wire inf = cfg_q[TD_INF]; // [RULE13]
   wire [1:0] sz = cfg_q[TD_SZ_L +: 2];
   wire [2:0] rd_b = phd_bytes(rd_rem_q, sz, inf);
   wire sv = st_q == ST_SAVE;
   wire sv_cancel = cancel_q[act_q];
   wire tdone = !inf && wr_rem_q == 17'h0;
   wire tend = cfg_q[TD_END];
   wire [CHCFG_W-1:0] acfg = chcfg_q[act_q];
   wire sv_td = sv && !sv_cancel && tdone;
   wire sv_end = sv_td && tend;
   wire chain_ev = sv_end && acfg[CH_CHAIN_EN];
   wire [CHW-1:0] chain_ch = acfg[CH_CHAIN_L +: CHW];
   ////////////////////////////////////////////////////////////////////////////
   // per-channel bits; a pend_q set beats a pend_q clear in the same cycle, but a save clears cancel_q over a new cancel
   always_ff @(posedge clk) begin
      if (reset) begin
         pend_q <= '0;
         run_q <= '0;
         mid_q <= '0;
         cancel_q <= '0;
         ch_irq_td <= '0;
         ch_irq_chain <= '0;
         for (int i = 0; i < NCH; i++) ch_td_q[i] <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (trig_rise[i] || apb_trig[i] || (chain_ev && chain_ch == CHW'(i))) begin // [RULE10]
               pend_q[i] <= 1'b1;
            end else if (apb_cancel[i] || (sv && act_q == CHW'(i) && (sv_cancel || sv_end))) begin
               pend_q[i] <= 1'b0;
            end
            ch_irq_td[i] <= sv_td && act_q == CHW'(i) && cfg_q[TD_IRQ0]; // [RULE11]
            ch_irq_chain[i] <= sv_end && act_q == CHW'(i) && cfg_q[TD_IRQ1];
            if (sv && act_q == CHW'(i)) begin
               cancel_q[i] <= 1'b0;
               run_q[i] <= !sv_cancel && !tdone;
               mid_q[i] <= sv_td && !tend;
               if (sv_td) ch_td_q[i] <= cfg_q[TD_NEXT_L +: TDW]; // [RULE14] [RULE15]
            end else if (apb_cancel[i]) begin
               // an active channel issues no further reads and stops once its accesses in flight finish
               if (busy && act_q == CHW'(i)) cancel_q[i] <= 1'b1; // [RULE12]
               else begin
                  run_q[i] <= 1'b0;
                  mid_q[i] <= 1'b0;
               end
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // arbitration
   logic [NCH-1:0][2:0] prio_v;
   logic [NCH-1:0] rroff_v, en_v;
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         prio_v[i] = chcfg_q[i][CH_PRIO_L +: 3];
         rroff_v[i] = chcfg_q[i][CH_RROFF];
         en_v[i] = chcfg_q[i][CH_EN];
      end
   end
   wire [NCH-1:0] arb_req = pend_q & en_v & ~stall_q & ~cancel_q;
   wire gnt_valid;
   wire [CHW-1:0] gnt_ch;
   wire take = st_q == ST_IDLE && gnt_valid; // [RULE17]
   phd_arbiter u_arb (
      .clk(clk),
      .reset(reset),
      .req(arb_req),
      .prio(prio_v),
      .rr_off(rroff_v),
      .fair_en(fair_en_q),
      .take(take),
      .gnt_valid(gnt_valid),
      .gnt_ch(gnt_ch)
   );
   ////////////////////////////////////////////////////////////////////////////
   // descriptor load
   wire resume = run_q[act_q];
   wire [TDW-1:0] ld_t = (resume || mid_q[act_q]) ? ch_td_q[act_q] : acfg[CH_FIRST_L +: TDW];
   wire [31:0] ld_cfg = td_cfg_q[ld_t];
   wire [15:0] ld_len16 = ld_cfg[TD_LEN_L +: 16];
   wire [16:0] ld_len = (ld_len16 == 16'h0) ? FULL_LEN : {1'b0, ld_len16};
   ////////////////////////////////////////////////////////////////////////////
   // data movement
   wire [NM-1:0] m_done;
   wire [NM-1:0][31:0] m_rdata;
   wire rd_done = m_done[M_RD];
   wire wr_done = m_done[M_WR];
   wire rd_more = (inf || rd_rem_q != 17'h0) && rd_n_q != BURST && !cancel_q[act_q];
   wire rd_go = st_q == ST_MOVE && rd_more && !rd_req_q && !hold_v_q;
   wire wr_go = st_q == ST_MOVE && hold_v_q && !wr_req_q;
   wire burst_end = !rd_more && !rd_req_q && !hold_v_q && !wr_req_q;
   always_ff @(posedge clk) begin
      if (reset) begin
         st_q <= ST_IDLE;
         act_q <= '0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (take) begin
                  act_q <= gnt_ch;
                  st_q <= ST_LOAD;
               end
            end
            ST_LOAD: st_q <= ST_MOVE;
            ST_MOVE: if (burst_end) st_q <= ST_SAVE;
            ST_SAVE: st_q <= ST_IDLE;
            default: st_q <= ST_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         td_q <= '0;
         cfg_q <= 32'h0;
         src_q <= 32'h0;
         dst_q <= 32'h0;
         rd_rem_q <= 17'h0;
         wr_rem_q <= 17'h0;
         rd_n_q <= 3'h0;
         wr_n_q <= 3'h0;
      end else if (st_q == ST_LOAD) begin
         td_q <= ld_t;
         cfg_q <= ld_cfg;
         rd_n_q <= 3'h0;
         wr_n_q <= 3'h0;
         src_q <= resume ? ch_src_q[act_q] : td_src_q[ld_t];
         dst_q <= resume ? ch_dst_q[act_q] : td_dst_q[ld_t];
         rd_rem_q <= resume ? ch_rem_q[act_q] : ld_len;
         wr_rem_q <= resume ? ch_rem_q[act_q] : ld_len;
      end else begin
         if (rd_done) begin
            src_q <= src_q + (cfg_q[TD_SINC] ? {29'h0, rd_b} : 32'h0);
            rd_rem_q <= inf ? rd_rem_q : rd_rem_q - {14'h0, rd_b};
            rd_n_q <= rd_n_q + 3'h1;
         end
         if (wr_done) begin
            dst_q <= dst_q + (cfg_q[TD_DINC] ? {29'h0, hold_b_q} : 32'h0);
            wr_rem_q <= inf ? wr_rem_q : wr_rem_q - {14'h0, hold_b_q};
            wr_n_q <= wr_n_q + 3'h1;
         end
      end
   end
   // single hold word lets read n+1 run while write n is on another spoke
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_req_q <= 1'b0;
         wr_req_q <= 1'b0;
         hold_v_q <= 1'b0;
         hold_q <= 32'h0;
         hold_b_q <= 3'h0;
         wr_data_q <= 32'h0;
         rd_sz_q <= 2'h0;
         wr_sz_q <= 2'h0;
      end else begin
         if (rd_go) begin
            rd_req_q <= 1'b1;
            rd_sz_q <= 2'(rd_b - 3'h1); // [RULE5]
         end else if (rd_done) begin
            rd_req_q <= 1'b0;
            hold_v_q <= 1'b1;
            hold_q <= m_rdata[M_RD];
            hold_b_q <= rd_b;
         end
         if (wr_go) begin // [RULE4]
            wr_req_q <= 1'b1;
            wr_data_q <= hold_q;
            wr_sz_q <= 2'(hold_b_q - 3'h1);
            hold_v_q <= 1'b0;
         end else if (wr_done) begin
            wr_req_q <= 1'b0;
         end
      end
   end
   // a stalled or pre-empted channel resumes from here [RULE12] [RULE17]
   always_ff @(posedge clk) begin
      if (sv) begin
         ch_src_q[act_q] <= src_q;
         ch_dst_q[act_q] <= dst_q;
         ch_rem_q[act_q] <= wr_rem_q;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // spokes
   phd_router u_router (
      .clk(clk),
      .reset(reset),
      .m_req({wr_req_q, rd_req_q, cpu_req}), // [RULE1]
      .m_addr({dst_q, src_q, cpu_addr}),
      .m_write({1'b1, 1'b0, cpu_write}),
      .m_wdata({wr_data_q, 32'h0, cpu_wdata}),
      .m_size({wr_sz_q, rd_sz_q, cpu_size}),
      .m_done(m_done),
      .m_rdata(m_rdata),
      .sp_valid(sp_valid),
      .sp_write(sp_write),
      .sp_addr(sp_addr),
      .sp_wdata(sp_wdata),
      .sp_size(sp_size),
      .sp_ready(sp_ready),
      .sp_rdata(sp_rdata)
   );
   assign cpu_done = m_done[M_CPU];
   assign cpu_rdata = m_rdata[M_CPU];
endmodule : phd_hub

// [rtl/phd_pkg.sv]
package phd_pkg;
   localparam int NCH = 24;
   localparam int NTD = 128;
   localparam int NSP = 8;
   localparam int NM = 3;
   localparam int CHW = 5;
   localparam int TDW = 7;
   // bus masters seen by the router
   localparam int M_CPU = 0;
   localparam int M_RD = 1;
   localparam int M_WR = 2;
   // spoke map, selected by address bits [18:16]
   localparam int SP_LSB = 16;
   localparam logic [2:0] SP_SRAM = 3'h0;
   localparam logic [2:0] SP_IO = 3'h1;
   localparam logic [2:0] SP_CFG = 3'h2;
   localparam logic [2:0] SP_ANALOG = 3'h3;
   localparam logic [2:0] SP_COMM = 3'h4;
   localparam logic [2:0] SP_FILTER = 3'h5;
   localparam logic [2:0] SP_LOGIC1 = 3'h6;
   localparam logic [2:0] SP_LOGIC2 = 3'h7;
   // register offsets
   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_STAT = 12'h004;
   localparam logic [11:0] A_TRIG = 12'h008;
   localparam logic [11:0] A_STALL = 12'h00c;
   localparam logic [11:0] A_CANCEL = 12'h010;
   localparam logic [11:0] A_PEND = 12'h014;
   localparam logic [11:0] A_CH = 12'h100;
   localparam logic [11:0] A_CH_END = 12'h160;
   localparam logic [11:0] A_TD = 12'h800;
   // descriptor word 2 layout
   localparam int TD_LEN_L = 0;
   localparam int TD_NEXT_L = 16;
   localparam int TD_INF = 23;
   localparam int TD_SZ_L = 24;
   localparam int TD_IRQ0 = 26;
   localparam int TD_IRQ1 = 27;
   localparam int TD_END = 28;
   localparam int TD_SINC = 29;
   localparam int TD_DINC = 30;
   // channel config layout
   localparam int CH_PRIO_L = 0;
   localparam int CH_RROFF = 3;
   localparam int CH_FIRST_L = 4;
   localparam int CH_EN = 11;
   localparam int CH_CHAIN_L = 12;
   localparam int CH_CHAIN_EN = 17;
   localparam int CHCFG_W = 18;
   localparam logic [2:0] BURST = 3'h4;
   localparam logic [16:0] FULL_LEN = 17'h10000;
   localparam int LVL_FAIR_MIN = 2;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOAD = 2'b01,
      ST_MOVE = 2'b11,
      ST_SAVE = 2'b10
   } phd_state_e;
   function automatic logic [2:0] phd_spoke(input logic [31:0] a);
      return a[SP_LSB +: 3];
   endfunction : phd_spoke
   function automatic logic [2:0] phd_bytes(input logic [16:0] rem, input logic [1:0] sz,
                                            input logic inf);
      logic [2:0] full;
      full = {1'b0, sz} + 3'h1;
      return (inf || rem >= {14'h0, full}) ? full : rem[2:0];
   endfunction : phd_bytes
endpackage : phd_pkg

// [rtl/phd_router.sv]
`timescale 1ns/10ps
module phd_router
   import phd_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [NM-1:0] m_req,
   input wire logic [NM-1:0][31:0] m_addr,
   input wire logic [NM-1:0] m_write,
   input wire logic [NM-1:0][31:0] m_wdata,
   input wire logic [NM-1:0][1:0] m_size,
   output logic [NM-1:0] m_done,
   output logic [NM-1:0][31:0] m_rdata,
   output logic [NSP-1:0] sp_valid,
   output logic [NSP-1:0] sp_write,
   output logic [NSP-1:0][31:0] sp_addr,
   output logic [NSP-1:0][31:0] sp_wdata,
   output logic [NSP-1:0][1:0] sp_size,
   input wire logic [NSP-1:0] sp_ready,
   input wire logic [NSP-1:0][31:0] sp_rdata
);
   logic [NSP-1:0] last_cpu_q;
   logic [NSP-1:0][1:0] own_q;
   logic [NM-1:0] done_d;
   logic [NM-1:0][31:0] rdata_d;
   // every spoke runs on its own, so masters on different spokes overlap [RULE2] [RULE3]
   for (genvar s = 0; s < NSP; s++) begin : g_sp
      logic [NM-1:0] want;
      always_comb begin
         for (int m = 0; m < NM; m++) begin
            want[m] = m_req[m] && !m_done[m] && phd_spoke(m_addr[m]) == 3'(s); // [RULE6]
         end
      end
      // cpu first, but after a cpu win a waiting dma goes next [RULE16]
      wire cpu_win = want[M_CPU] && !(last_cpu_q[s] && (want[M_RD] || want[M_WR]));
      wire [1:0] pick = cpu_win ? 2'(M_CPU) : (want[M_WR] ? 2'(M_WR) : 2'(M_RD));
      always_ff @(posedge clk) begin
         if (reset) begin
            sp_valid[s] <= 1'b0;
            sp_write[s] <= 1'b0;
            sp_addr[s] <= 32'h0;
            sp_wdata[s] <= 32'h0;
            sp_size[s] <= 2'h0;
            own_q[s] <= 2'h0;
            last_cpu_q[s] <= 1'b0;
         end else if (sp_valid[s] && sp_ready[s]) begin
            sp_valid[s] <= 1'b0;
         end else if (!sp_valid[s] && |want) begin
            sp_valid[s] <= 1'b1;
            own_q[s] <= pick;
            sp_write[s] <= m_write[pick];
            sp_addr[s] <= m_addr[pick];
            sp_wdata[s] <= m_wdata[pick];
            sp_size[s] <= m_size[pick]; // [RULE5]
            last_cpu_q[s] <= cpu_win;
         end
      end
   end
   always_comb begin
      done_d = '0;
      rdata_d = '0;
      for (int s = 0; s < NSP; s++) begin
         if (sp_valid[s] && sp_ready[s]) begin
            done_d[own_q[s]] = 1'b1;
            rdata_d[own_q[s]] = sp_rdata[s];
         end
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         m_done <= '0;
         m_rdata <= '0;
      end else begin
         m_done <= done_d; // [RULE1]
         m_rdata <= rdata_d;
      end
   end
endmodule : phd_router

// [tb/phd_hub_asserts.sv]
`timescale 1ns/10ps
module phd_hub_asserts
   import phd_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic cpu_req,
   input wire logic cpu_done,
   input wire logic [NSP-1:0] sp_valid,
   input wire logic [NSP-1:0][31:0] sp_addr,
   input wire logic [NSP-1:0] sp_ready,
   input wire logic [NCH-1:0] ch_irq_td,
   input wire logic [NCH-1:0] ch_irq_chain
);
   logic bad_map;
   always_comb begin
      bad_map = 1'h0;
      for (int s = 0; s < NSP; s++) begin
         if (sp_valid[s] && sp_addr[s][18:16] != 3'(s)) begin
            bad_map = 1'h1;
         end
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   AST_APB_WAIT: assert property ($rose(penable) && psel |=> pready)
      else $error("ready not one cycle after access start");
   AST_APB_ONE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_ERR_READY: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error without ready or with data");
   AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside ready cycle");
   AST_SP_HOLD: assert property ((sp_valid & ~sp_ready) != '0 |=>
      ($past(sp_valid & ~sp_ready) & ~sp_valid) == '0) else $error("spoke dropped early");
   AST_SPOKE_MAP: assert property (!bad_map)
      else $error("access on wrong spoke");
   AST_CPU_DONE: assert property (cpu_done |-> $past(sp_valid & sp_ready) != '0)
      else $error("done without spoke completion");
   AST_CPU_BOUND: assert property ($rose(cpu_req) |-> ##[2:80] cpu_done)
      else $error("cpu access starved");
   AST_IRQ_PULSE: assert property (ch_irq_td != '0 |=> (ch_irq_td & $past(ch_irq_td)) == '0)
      else $error("descriptor irq not a pulse");
   AST_CHAIN_PULSE: assert property ((ch_irq_chain & $past(ch_irq_chain)) == '0)
      else $error("chain irq not a pulse");
endmodule : phd_hub_asserts
bind phd_hub phd_hub_asserts phd_hub_asserts_inst (.*);

// [tb/phd_spoke_model.sv]
`timescale 1ns/10ps
module phd_spoke_model
   import phd_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic slow,
   input wire logic [NSP-1:0] sp_valid,
   input wire logic [NSP-1:0] sp_write,
   input wire logic [NSP-1:0][31:0] sp_addr,
   input wire logic [NSP-1:0][31:0] sp_wdata,
   output logic [NSP-1:0] sp_ready,
   output logic [NSP-1:0][31:0] sp_rdata
);
   logic [31:0] mem [NSP][64];
   logic [NSP-1:0] wait_q;
   // outside ready the data is inverted so a stale word never passes
   always_comb begin
      for (int s = 0; s < NSP; s++) begin
         sp_rdata[s] = mem[s][sp_addr[s][7:2]];
         if (!sp_ready[s]) sp_rdata[s] = ~sp_rdata[s];
      end
   end
   always @(posedge clk) begin
      for (int s = 0; s < NSP; s++) begin
         sp_ready[s] <= !reset && sp_valid[s] && !sp_ready[s] && (!slow || wait_q[s]);
         wait_q[s] <= !reset && sp_valid[s] && !sp_ready[s] && !wait_q[s];
         if (sp_valid[s] && sp_ready[s] && sp_write[s]) mem[s][sp_addr[s][7:2]] <= sp_wdata[s];
      end
   end
endmodule : phd_spoke_model

// [tb/tb.sv]
`timescale 1ns/10ps
module tb import phd_pkg::*;;
   logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
   logic cpu_req = 0, cpu_write = 0, slow = 0, pready, pslverr, cpu_done, e;
   logic [31:0] paddr = '0, pwdata = '0, prdata, cpu_addr = '0, cpu_wdata = '0, cpu_rdata, r;
   logic [1:0] cpu_size = 2'h3;
   logic [NCH-1:0] trig_in = '0, ch_irq_td, ch_irq_chain;
   logic [NSP-1:0] sp_valid, sp_write, sp_ready;
   logic [NSP-1:0][31:0] sp_addr, sp_wdata, sp_rdata;
   logic [NSP-1:0][1:0] sp_size;
   int n_errors = 0, total_checks = 0, n_td = 0, n_wr = 0, n, m;
   phd_hub phd_hub_inst (.*);
   phd_spoke_model phd_spoke_model_inst (.*);
   initial forever #50 clk = ~clk;
   always @(posedge clk) begin
      if (ch_irq_td[0] === 1'h1) n_td++;
      if (sp_valid[4] === 1'h1 && sp_ready[4] === 1'h1) n_wr++;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) begin
         n_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, x);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {20'h0, a};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask : apb
   task automatic cpu(input logic w, input logic [31:0] a, input logic [31:0] d);
      cpu_req <= 1'h1;
      cpu_write <= w;
      cpu_addr <= a;
      cpu_wdata <= d;
      do @(posedge clk); while (cpu_done !== 1'h1);
      r = cpu_rdata;
      cpu_req <= 1'h0;
      @(posedge clk);
   endtask : cpu
   ////////////////////////////////////////////////////////////////
   task automatic t_regs;
      apb(1'h1, A_CTRL, 32'h1);
      apb(1'h0, A_CTRL, '0);
      chk(r, 32'h1);
      apb(1'h1, A_CH + 12'h8, 32'h3ffff);
      apb(1'h0, A_CH + 12'h8, '0);
      chk(r, 32'h3ffff);
      apb(1'h1, A_CH + 12'h8, '0);
      apb(1'h1, A_TD + 12'h10, 32'h1234abcd);
      apb(1'h0, A_TD + 12'h10, '0);
      chk(r, 32'h1234abcd);
      apb(1'h0, 12'h7f0, '0);
      chk({31'h0, e}, 32'h1);
   endtask : t_regs
   task automatic t_cpu;
      for (int s = 0; s < NSP; s++) cpu(1'h1, {13'h0, 3'(s), 16'h40}, 32'hc0de0000 + s);
      slow <= 1'h1;
      for (int s = 0; s < NSP; s++) begin
         cpu(1'h0, {13'h0, 3'(s), 16'h40}, '0);
         chk(r, 32'hc0de0000 + s);
      end
      slow <= 1'h0;
   endtask : t_cpu
   task automatic t_dma;
      cpu(1'h1, 32'h10, 32'h11223344);
      cpu(1'h1, 32'h14, 32'h55667788);
      apb(1'h1, A_TD, 32'h10);
      apb(1'h1, A_TD + 12'h4, 32'h30020);
      apb(1'h1, A_TD + 12'h8, 32'h7f000008);
      apb(1'h1, A_CH, 32'h800);
      apb(1'h1, A_TRIG, 32'h1);
      n = 0;
      do @(posedge clk); while (ch_irq_chain[0] !== 1'h1 && ++n < 300);
      chk({31'h0, ch_irq_chain[0]}, 32'h1);
      cpu(1'h0, 32'h30020, '0);
      chk(32'(n_td), 32'h1);
      chk(r, 32'h11223344);
      cpu(1'h0, 32'h30024, '0);
      chk(r, 32'h55667788);
   endtask : t_dma
   task automatic t_cancel;
      apb(1'h1, A_TD + 12'h14, 32'h40000);
      apb(1'h1, A_TD + 12'h18, 32'h03810004);
      apb(1'h1, A_CH + 12'h4, 32'h812);
      trig_in <= 24'h2;
      cpu(1'h1, 32'h60080, 32'h600d0006);
      cpu(1'h0, 32'h60080, '0);
      chk(r, 32'h600d0006);
      repeat (60) @(posedge clk);
      chk({31'h0, n_wr > 2}, 32'h1);
      apb(1'h1, A_CANCEL, 32'h2);
      repeat (60) @(posedge clk);
      m = n_wr;
      repeat (40) @(posedge clk);
      chk(32'(n_wr), 32'(m));
      trig_in <= '0;
   endtask : t_cancel
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      tally_and_finish();
   end
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'h0;
      @(posedge clk);
      t_regs();
      t_cpu();
      t_dma();
      t_cancel();
      tally_and_finish();
   end
endmodule : tb
